//--- core/sbst_params.svh
// constants of the sram boundary-scan tap: instruction codes, register
// sizes, state codes and link timing figures.
// assumes it is included by the package, by the tap, by the assertions and by the testbench.
`ifndef SBST_PARAMS_SVH
`define SBST_PARAMS_SVH

// ****************************************************************
// instruction register
// ****************************************************************
`define SBST_IR_W        3
`define SBST_IR_EXTEST   3'h0
`define SBST_IR_IDCODE   3'h1
`define SBST_IR_SAMPZ    3'h2
`define SBST_IR_PRELOAD  3'h4
`define SBST_IR_BYPASS   3'h7
`define SBST_IR_CAPT_LO  2'h1
`define SBST_IR_CAPT_HI  1'h0

// ****************************************************************
// data registers
// ****************************************************************
`define SBST_ID_W        32
`define SBST_BSR_LEN     109
`define SBST_PIN_CELLS   108
`define SBST_DRV_CELL    108
`define SBST_BYP_CAPT    1'h0
`define SBST_DRV_PRESET  1'h1
`define SBST_FIFO_DEPTH  8
`define SBST_SYNC_STAGES 2

// ****************************************************************
// link timing: fastest legal test clock against the core clock
// ****************************************************************
`define SBST_TCK_MAX_MHZ 20
`define SBST_CORE_MHZ    125
`define SBST_TCK_MIN_CYC \
  ((`SBST_CORE_MHZ + `SBST_TCK_MAX_MHZ - 1) / `SBST_TCK_MAX_MHZ)

// ****************************************************************
// tap state codes, gray along the usual path
// ****************************************************************
`define SBST_S_TLR    4'h0
`define SBST_S_RTI    4'h1
`define SBST_S_SELDR  4'h3
`define SBST_S_CAPDR  4'h2
`define SBST_S_SHDR   4'h6
`define SBST_S_EX1DR  4'h7
`define SBST_S_PAUDR  4'h5
`define SBST_S_EX2DR  4'h4
`define SBST_S_UPDDR  4'hc
`define SBST_S_SELIR  4'hd
`define SBST_S_CAPIR  4'hf
`define SBST_S_SHIR   4'he
`define SBST_S_EX1IR  4'ha
`define SBST_S_PAUIR  4'hb
`define SBST_S_EX2IR  4'h9
`define SBST_S_UPDIR  4'h8

`endif

//--- core/sbst_pkg.sv
// types shared by the boundary-scan tap and its helpers.
// assumes sbst_params.svh sits beside it.
`include "sbst_params.svh"

package sbst_pkg;

  typedef enum logic [3:0]
  {
    SBST_TLR   = `SBST_S_TLR,
    SBST_RTI   = `SBST_S_RTI,
    SBST_SELDR = `SBST_S_SELDR,
    SBST_CAPDR = `SBST_S_CAPDR,
    SBST_SHDR  = `SBST_S_SHDR,
    SBST_EX1DR = `SBST_S_EX1DR,
    SBST_PAUDR = `SBST_S_PAUDR,
    SBST_EX2DR = `SBST_S_EX2DR,
    SBST_UPDDR = `SBST_S_UPDDR,
    SBST_SELIR = `SBST_S_SELIR,
    SBST_CAPIR = `SBST_S_CAPIR,
    SBST_SHIR  = `SBST_S_SHIR,
    SBST_EX1IR = `SBST_S_EX1IR,
    SBST_PAUIR = `SBST_S_PAUIR,
    SBST_EX2IR = `SBST_S_EX2IR,
    SBST_UPDIR = `SBST_S_UPDIR
  } sbst_state_t;

  // the three test-port inputs, sampled together
  typedef struct packed
  {
    logic tck;
    logic tms;
    logic tdi;
  } sbst_tap_in_t;

  // pin snapshot of the sram ring, one bit per pin cell
  typedef logic [`SBST_PIN_CELLS-1:0] sbst_pins_t;

  // everything the tap keeps between core clock edges
  typedef struct packed
  {
    sbst_state_t               st;
    logic [`SBST_IR_W-1:0]     ir;
    logic [`SBST_IR_W-1:0]     ir_sh;
    logic [`SBST_ID_W-1:0]     id_sh;
    logic                      byp;
    logic [`SBST_BSR_LEN-1:0]  bsr_sh;
    logic [`SBST_BSR_LEN-1:0]  pre;
    sbst_pins_t                snap;
    logic                      tck_prev;
    logic                      tdo;
    logic                      tdo_oe;
  } sbst_regs_t;

endpackage

//--- core/sbst_sync.sv
// two-flop synchroniser for a group of asynchronous inputs.
// assumes the inputs are levels that are stable for several core clocks.
`timescale 1ns/1ps

module sbst_sync
#(
  parameter int W = 3
)
(
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed
  {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sbst_sync_regs_t;

  sbst_sync_regs_t s_q;
  sbst_sync_regs_t s_d;

  // first stage feeds the second stage only
  always_comb
  begin
    s_d.s1 = async_in;
    s_d.s2 = s_q.s1;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.s2;

endmodule

//--- core/sbst_fifo.sv
// small first-in first-out buffer with valid/ready on both sides.
// assumes depth is a power of two; output data comes from storage flops.
`timescale 1ns/1ps

module sbst_fifo
#(
  parameter int W     = 8,
  parameter int DEPTH = 8
)
(
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed
  {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             cnt;
  } sbst_fifo_regs_t;

  sbst_fifo_regs_t s_q;
  sbst_fifo_regs_t s_d;
  logic            push;
  logic            pop;

  assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data  = s_q.mem[s_q.rd];

  always_comb
  begin
    s_d  = s_q;
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    if (push)
    begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr          = s_q.wr + AW'(1);
    end
    if (pop)
    begin
      s_d.rd = s_q.rd + AW'(1);
    end
    if (push && !pop)
    begin
      s_d.cnt = s_q.cnt + (AW+1)'(1);
    end
    else if (pop && !push)
    begin
      s_d.cnt = s_q.cnt - (AW+1)'(1);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

endmodule

//--- core/sbst_tap.sv
// boundary-scan test access port of a synchronous burst sram.
// assumes the test port pins are asynchronous to core_clk, the test clock
// runs well below a fifth of core_clk, and pin snapshots of the sram ring
// arrive on core_clk through a valid/ready stream.
`timescale 1ns/1ps
`include "sbst_params.svh"

// Notes on behaviour
// - reset and test-logic-reset load the identification instruction.
// - identification connects the 32-bit id register and shifts it out.
// - sample-high-impedance puts the boundary register in the shift path.
// - sample-high-impedance floats the read-data bus until next update-ir or test-logic-reset.
// - sample/preload captures the pin values in capture-dr.
// - a pin moving during capture may be caught either way.
// - after capture, shift-dr moves the boundary register out on tdo.
// - preload latches the shifted pattern into the parallel cell outputs.
// - captured data shifts out while new preload data shifts in.
// - bypass routes tdi to tdo through one bypass bit.
// - extest drives the preloaded values onto the system pins.
// - extest also puts the boundary register in the shift path.
// - cell 108, latched at update-dr, governs read-data drive under extest.
// - drive cell 1 drives the read-data bus, 0 floats it.
// - drive cell shifted in sample/preload or extest, latched at update-dr.
// - drive cell presets to 1 at reset and in test-logic-reset.
// - state moves follow tms sampled at each test clock rise.
// - codes 000,001,010,100,111 decode; 011,101,110 are reserved.
// - capture-ir loads 01 into the low instruction bits.
// - five rises with tms high reach test-logic-reset.
// - capture-dr under identification loads the hardwired 32-bit code.
module sbst_tap
#(
  // arbitrary neutral identification value; bit 0 marks id presence
  parameter logic [`SBST_ID_W-1:0] ID_CODE = 32'h0abc_d001,
  parameter int                    DEPTH   = `SBST_FIFO_DEPTH
)
(
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire sbst_pkg::sbst_tap_in_t tap_in,
  output logic                       tdo,
  output logic                       tdo_oe,
  input  wire logic                  snap_valid,
  output logic                       snap_ready,
  input  wire sbst_pkg::sbst_pins_t  snap_data,
  output sbst_pkg::sbst_pins_t       pin_drive,
  output logic                       extest_active,
  output logic                       rdata_oe,
  output logic [`SBST_IR_W-1:0]      cur_instr
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  sbst_pkg::sbst_regs_t   s_q;
  sbst_pkg::sbst_regs_t   s_d;
  sbst_pkg::sbst_tap_in_t tap_s;
  sbst_pkg::sbst_pins_t   fifo_data;
  logic                   fifo_valid;
  logic                   fifo_ready;
  logic                   tck_rise;
  logic                   tck_fall;
  logic                   sel_bsr;
  logic                   sel_id;
  logic                   may_preload;

  // ****************************************************************
  // pin synchroniser and snapshot buffer
  // ****************************************************************
  sbst_sync
  #(
    .W ($bits(sbst_pkg::sbst_tap_in_t))
  )
  u_sync
  (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (tap_in),
    .sync_out (tap_s)
  );

  sbst_fifo
  #(
    .W     (`SBST_PIN_CELLS),
    .DEPTH (DEPTH)
  )
  u_fifo
  (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (snap_valid),
    .in_ready  (snap_ready),
    .in_data   (snap_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .out_data  (fifo_data)
  );

  // the snapshot freezes while in capture-dr so the sampled ring is
  // stable across the capture edge; the buffer absorbs the backlog
  assign fifo_ready = (s_q.st != sbst_pkg::SBST_CAPDR);

  // ****************************************************************
  // test clock edges and register selection
  // ****************************************************************
  assign tck_rise = tap_s.tck && !s_q.tck_prev;
  assign tck_fall = !tap_s.tck && s_q.tck_prev;

  // reserved codes fall back to the bypass bit
  assign sel_id  = (s_q.ir == `SBST_IR_IDCODE);
  assign sel_bsr = (s_q.ir == `SBST_IR_EXTEST) ||
                   (s_q.ir == `SBST_IR_SAMPZ) ||
                   (s_q.ir == `SBST_IR_PRELOAD);
  assign may_preload = (s_q.ir == `SBST_IR_EXTEST) ||
                       (s_q.ir == `SBST_IR_PRELOAD);

  // ****************************************************************
  // tap state transitions
  // ****************************************************************
  function automatic sbst_pkg::sbst_state_t next_state
  (
    input sbst_pkg::sbst_state_t st,
    input logic                  tms
  );
    sbst_pkg::sbst_state_t nx;
    nx = st;
    unique case (st)
      sbst_pkg::SBST_TLR:
        nx = tms ? sbst_pkg::SBST_TLR : sbst_pkg::SBST_RTI;
      sbst_pkg::SBST_RTI:
        nx = tms ? sbst_pkg::SBST_SELDR : sbst_pkg::SBST_RTI;
      sbst_pkg::SBST_SELDR:
        nx = tms ? sbst_pkg::SBST_SELIR : sbst_pkg::SBST_CAPDR;
      sbst_pkg::SBST_CAPDR:
        nx = tms ? sbst_pkg::SBST_EX1DR : sbst_pkg::SBST_SHDR;
      sbst_pkg::SBST_SHDR:
        nx = tms ? sbst_pkg::SBST_EX1DR : sbst_pkg::SBST_SHDR;
      sbst_pkg::SBST_EX1DR:
        nx = tms ? sbst_pkg::SBST_UPDDR : sbst_pkg::SBST_PAUDR;
      sbst_pkg::SBST_PAUDR:
        nx = tms ? sbst_pkg::SBST_EX2DR : sbst_pkg::SBST_PAUDR;
      sbst_pkg::SBST_EX2DR:
        nx = tms ? sbst_pkg::SBST_UPDDR : sbst_pkg::SBST_SHDR;
      sbst_pkg::SBST_UPDDR:
        nx = tms ? sbst_pkg::SBST_SELDR : sbst_pkg::SBST_RTI;
      sbst_pkg::SBST_SELIR:
        nx = tms ? sbst_pkg::SBST_TLR : sbst_pkg::SBST_CAPIR;
      sbst_pkg::SBST_CAPIR:
        nx = tms ? sbst_pkg::SBST_EX1IR : sbst_pkg::SBST_SHIR;
      sbst_pkg::SBST_SHIR:
        nx = tms ? sbst_pkg::SBST_EX1IR : sbst_pkg::SBST_SHIR;
      sbst_pkg::SBST_EX1IR:
        nx = tms ? sbst_pkg::SBST_UPDIR : sbst_pkg::SBST_PAUIR;
      sbst_pkg::SBST_PAUIR:
        nx = tms ? sbst_pkg::SBST_EX2IR : sbst_pkg::SBST_PAUIR;
      sbst_pkg::SBST_EX2IR:
        nx = tms ? sbst_pkg::SBST_UPDIR : sbst_pkg::SBST_SHIR;
      sbst_pkg::SBST_UPDIR:
        nx = tms ? sbst_pkg::SBST_SELDR : sbst_pkg::SBST_RTI;
    endcase
    return nx;
  endfunction

  // ****************************************************************
  // register actions on test clock edges
  // ****************************************************************
  always_comb
  begin
    s_d          = s_q;
    s_d.tck_prev = tap_s.tck;
    if (fifo_valid && fifo_ready)
    begin
      s_d.snap = fifo_data;
    end
    // defaults hold for as long as the state is test-logic-reset, so
    // they are back at once, not only at the next test clock rise
    if (s_q.st == sbst_pkg::SBST_TLR)
    begin
      s_d.ir                  = `SBST_IR_IDCODE;
      s_d.pre[`SBST_DRV_CELL] = `SBST_DRV_PRESET;
    end
    if (tck_rise)
    begin
      unique case (s_q.st)
        sbst_pkg::SBST_CAPIR:
        begin
          s_d.ir_sh = {`SBST_IR_CAPT_HI, `SBST_IR_CAPT_LO};
        end
        sbst_pkg::SBST_SHIR:
        begin
          s_d.ir_sh = {tap_s.tdi, s_q.ir_sh[`SBST_IR_W-1:1]};
        end
        sbst_pkg::SBST_UPDIR:
        begin
          // a new code takes effect here or in test-logic-reset, ending any high-z hold
          s_d.ir = s_q.ir_sh;
        end
        sbst_pkg::SBST_CAPDR:
        begin
          if (sel_id)
          begin
            s_d.id_sh = ID_CODE;
          end
          else if (sel_bsr)
          begin
            // a pin moving near this edge may land either way
            s_d.bsr_sh = {s_q.pre[`SBST_DRV_CELL], s_q.snap};
          end
          else
          begin
            s_d.byp = `SBST_BYP_CAPT;
          end
        end
        sbst_pkg::SBST_SHDR:
        begin
          if (sel_id)
          begin
            s_d.id_sh = {tap_s.tdi, s_q.id_sh[`SBST_ID_W-1:1]};
          end
          else if (sel_bsr)
          begin
            // capture leaves by tdo as preload enters by tdi
            s_d.bsr_sh = {tap_s.tdi,
                          s_q.bsr_sh[`SBST_BSR_LEN-1:1]};
          end
          else
          begin
            s_d.byp = tap_s.tdi;
          end
        end
        sbst_pkg::SBST_UPDDR:
        begin
          if (may_preload)
          begin
            s_d.pre = s_q.bsr_sh;
          end
        end
        sbst_pkg::SBST_TLR,
        sbst_pkg::SBST_RTI,
        sbst_pkg::SBST_SELDR,
        sbst_pkg::SBST_EX1DR,
        sbst_pkg::SBST_PAUDR,
        sbst_pkg::SBST_EX2DR,
        sbst_pkg::SBST_SELIR,
        sbst_pkg::SBST_EX1IR,
        sbst_pkg::SBST_PAUIR,
        sbst_pkg::SBST_EX2IR:
        begin
          s_d.byp = s_q.byp;
        end
      endcase
      s_d.st = next_state(s_q.st, tap_s.tms);
    end
    else if (tck_fall)
    begin
      // tdo follows the register's low bit on the falling edge
      s_d.tdo_oe = (s_q.st == sbst_pkg::SBST_SHIR) ||
                   (s_q.st == sbst_pkg::SBST_SHDR);
      if (s_q.st == sbst_pkg::SBST_SHIR)
      begin
        s_d.tdo = s_q.ir_sh[0];
      end
      else if (sel_id)
      begin
        s_d.tdo = s_q.id_sh[0];
      end
      else if (sel_bsr)
      begin
        s_d.tdo = s_q.bsr_sh[0];
      end
      else
      begin
        s_d.tdo = s_q.byp;
      end
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_q                     <= '0;
      s_q.st                  <= sbst_pkg::SBST_TLR;
      s_q.ir                  <= `SBST_IR_IDCODE;
      s_q.pre[`SBST_DRV_CELL] <= `SBST_DRV_PRESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // outputs toward the sram ring
  // ****************************************************************
  assign tdo           = s_q.tdo;
  assign tdo_oe        = s_q.tdo_oe;
  assign cur_instr     = s_q.ir;
  assign pin_drive     = s_q.pre[`SBST_PIN_CELLS-1:0];
  assign extest_active = (s_q.ir == `SBST_IR_EXTEST);

  // read-data bus drive: high-z under sample-z, drive cell under extest
  always_comb
  begin
    if (s_q.ir == `SBST_IR_SAMPZ)
    begin
      rdata_oe = 1'b0;
    end
    else if (s_q.ir == `SBST_IR_EXTEST)
    begin
      rdata_oe = s_q.pre[`SBST_DRV_CELL];
    end
    else
    begin
      rdata_oe = 1'b1;
    end
  end

endmodule

//--- bench/sbst_tap_assertions.sv
// concurrent checks on the boundary-scan tap ports, bound to sbst_tap.
// assumes the test clock pins move slowly against core_clk.
`timescale 1ns/1ps
`include "sbst_params.svh"

module sbst_tap_assertions
(
  input wire logic                   core_clk,
  input wire logic                   rst,
  input wire sbst_pkg::sbst_tap_in_t tap_in,
  input wire logic                   tdo,
  input wire logic                   tdo_oe,
  input wire sbst_pkg::sbst_pins_t   pin_drive,
  input wire logic                   extest_active,
  input wire logic                   rdata_oe,
  input wire logic [`SBST_IR_W-1:0]  cur_instr
);
  logic [3:0] rise_age_q;
  logic [3:0] fall_age_q;

  // core cycles since the last pin edge; saturates so it never wraps
  always_ff @(posedge core_clk)
  begin
    rise_age_q <= rst ? 4'hf : $rose(tap_in.tck) ? 4'h0 :
                  rise_age_q + {3'h0, rise_age_q != 4'hf};
    fall_age_q <= rst ? 4'hf : $fell(tap_in.tck) ? 4'h0 :
                  fall_age_q + {3'h0, fall_age_q != 4'hf};
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // ********
  // properties
  // ********
  sequence s_near_rise;
    rise_age_q inside {[0:4]};
  endsequence
  sequence s_near_fall;
    fall_age_q inside {[0:4]};
  endsequence

  property p_rst_dflt;
    $fell(rst) |-> cur_instr == `SBST_IR_IDCODE && rdata_oe && !tdo_oe;
  endproperty
  a_rst_dflt: assert property (p_rst_dflt)
    else $error("reset defaults wrong");
  property p_ext_dec;
    extest_active == (cur_instr == `SBST_IR_EXTEST);
  endproperty
  a_ext_dec: assert property (p_ext_dec)
    else $error("extest decode wrong");
  property p_sampz;
    cur_instr == `SBST_IR_SAMPZ |-> !rdata_oe;
  endproperty
  a_sampz: assert property (p_sampz)
    else $error("read bus driven under sample-z");
  property p_plain;
    cur_instr inside {`SBST_IR_IDCODE, `SBST_IR_PRELOAD, `SBST_IR_BYPASS}
      |-> rdata_oe;
  endproperty
  a_plain: assert property (p_plain)
    else $error("read bus floated outside extest");
  property p_tdo;
    $changed(tdo) |-> s_near_fall;
  endproperty
  a_tdo: assert property (p_tdo)
    else $error("tdo moved away from a falling edge");
  property p_tdo_oe;
    $changed(tdo_oe) |-> s_near_fall;
  endproperty
  a_tdo_oe: assert property (p_tdo_oe)
    else $error("tdo enable moved away from a falling edge");
  property p_instr;
    $changed(cur_instr) |-> s_near_rise;
  endproperty
  a_instr: assert property (p_instr)
    else $error("instruction moved away from a rising edge");
  property p_oe;
    $changed(rdata_oe) |-> s_near_rise;
  endproperty
  a_oe: assert property (p_oe)
    else $error("read bus enable moved away from a rising edge");
  property p_pins;
    $changed(pin_drive) |-> s_near_rise ##0
      cur_instr inside {`SBST_IR_EXTEST, `SBST_IR_PRELOAD};
  endproperty
  a_pins: assert property (p_pins)
    else $error("preload latched under wrong instruction");
endmodule

bind sbst_tap sbst_tap_assertions u_sbst_tap_assertions
(
  .core_clk(core_clk), .rst(rst), .tap_in(tap_in), .tdo(tdo),
  .tdo_oe(tdo_oe), .pin_drive(pin_drive), .extest_active(extest_active),
  .rdata_oe(rdata_oe), .cur_instr(cur_instr)
);

//--- bench/sbst_jtag_ctl.sv
// board test controller model driving the tap pins.
// assumes the caller starts each scan from run-test-idle.
`timescale 1ns/1ps

module sbst_jtag_ctl
(
  input  wire logic              tdo,
  input  wire logic              tdo_oe,
  output sbst_pkg::sbst_tap_in_t tap_in
);
  // 80 ns period keeps under the 20 MHz ceiling
  localparam time HALF = 40ns;

  // clock stands low between frames, tms and tdi rest at pull-up level
  initial tap_in = 3'b011;

  task automatic step(input logic m, input logic d, output logic o);
    tap_in.tms = m;
    tap_in.tdi = d;
    #HALF;
    o = tdo_oe ? tdo : 1'bz; // undriven tdo never compares equal
    tap_in.tck = 1'b1;
    #HALF;
    tap_in.tck = 1'b0;
  endtask

  task automatic reset5();
    logic o;
    repeat (5) step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask

  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b1, o);
    if (ir)
      step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    step(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask
endmodule

//--- bench/sbst_tap_tb.sv
// self-checking bench for sbst_tap with a controller model.
// assumes design files and sbst_params.svh are compiled first.
`timescale 1ns/1ps
`include "sbst_params.svh"

module sbst_tap_tb;
  // arbitrary id value, bit 0 set
  localparam logic [31:0]  ID  = 32'h1357_2461;
  localparam logic [127:0] DIN = 128'h9e37_79b9_7f4a_7c15_f39c_c060_5ced_c834;
  localparam logic [107:0] S   = 108'h5a5_c3c3_0ff0_1234_5678_9abc_def0;

  logic                   core_clk   = 1'b0;
  logic                   rst        = 1'b1;
  sbst_pkg::sbst_tap_in_t tap_in;
  logic                   tdo;
  logic                   tdo_oe;
  logic                   snap_valid = 1'b0;
  logic                   snap_ready;
  sbst_pkg::sbst_pins_t   snap_data  = S; // ring held still
  sbst_pkg::sbst_pins_t   pin_drive;
  logic                   extest_active;
  logic                   rdata_oe;
  logic [`SBST_IR_W-1:0]  cur_instr;
  int                     error_cnt  = 0;
  int                     n_tests    = 0;
  logic [2:0]             codes [5]  = '{`SBST_IR_EXTEST, `SBST_IR_IDCODE,
    `SBST_IR_SAMPZ, `SBST_IR_PRELOAD, `SBST_IR_BYPASS};

  always #4 core_clk = ~core_clk;

  sbst_tap #(.ID_CODE(ID), .DEPTH(8)) u_sbst_tap
  (
    .core_clk(core_clk), .rst(rst), .tap_in(tap_in), .tdo(tdo),
    .tdo_oe(tdo_oe), .snap_valid(snap_valid), .snap_ready(snap_ready),
    .snap_data(snap_data), .pin_drive(pin_drive),
    .extest_active(extest_active), .rdata_oe(rdata_oe),
    .cur_instr(cur_instr)
  );
  sbst_jtag_ctl u_sbst_jtag_ctl
  (
    .tdo(tdo), .tdo_oe(tdo_oe), .tap_in(tap_in)
  );

  // ********
  // compares and closing
  // ********
  task automatic chk_vec(input logic [127:0] got, input logic [127:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_vec({127'h0, got}, {127'h0, exp});
  endtask
  task automatic final_report();
    if (error_cnt == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ********
  // scenarios
  // ********
  task automatic check_reset();
    chk_vec(cur_instr, `SBST_IR_IDCODE);
    chk_bit(rdata_oe, 1'b1);
    chk_bit(extest_active, 1'b0);
    chk_bit(tdo_oe, 1'b0);
    chk_vec(pin_drive, '0);
    chk_bit(snap_ready, 1'b1);
  endtask

  task automatic load_ir(input logic [2:0] c);
    logic [127:0] d;
    u_sbst_jtag_ctl.scan(1'b1, 3, {125'h0, c}, d);
    chk_vec(d[2:0], 3'h1);
    chk_vec(cur_instr, c);
  endtask

  // capture, shift length and preload per instruction
  task automatic run_code(input logic [2:0] c);
    logic [127:0] d;
    logic [127:0] head;
    int           len;
    len  = c == `SBST_IR_IDCODE ? `SBST_ID_W :
           c == `SBST_IR_BYPASS ? 1 : `SBST_BSR_LEN;
    head = c == `SBST_IR_IDCODE ? {96'h0, ID} :
           c == `SBST_IR_BYPASS ? 128'h0 : {19'h0, `SBST_DRV_PRESET, S};
    load_ir(c);
    chk_bit(extest_active, c == `SBST_IR_EXTEST);
    u_sbst_jtag_ctl.scan(1'b0, 128, DIN, d);
    chk_vec(d & ~(~128'h0 << len), head);
    chk_vec(d >> len, DIN & (~128'h0 >> len));
    chk_bit(rdata_oe, c != `SBST_IR_SAMPZ);
    if (c == `SBST_IR_EXTEST || c == `SBST_IR_PRELOAD)
      chk_vec(pin_drive, DIN[126:19]);
  endtask

  // drive cell cleared under extest, then tap reset from shift-dr
  task automatic drive_cell();
    logic [127:0] d;
    logic         o;
    load_ir(`SBST_IR_EXTEST);
    u_sbst_jtag_ctl.scan(1'b0, 128, DIN & ~(128'h1 << 127), d);
    chk_bit(rdata_oe, 1'b0);
    u_sbst_jtag_ctl.step(1'b1, 1'b1, o);
    u_sbst_jtag_ctl.step(1'b0, 1'b1, o);
    u_sbst_jtag_ctl.step(1'b0, 1'b1, o);
    u_sbst_jtag_ctl.reset5();
    chk_vec(cur_instr, `SBST_IR_IDCODE);
    load_ir(`SBST_IR_EXTEST);
    chk_bit(rdata_oe, 1'b1);
  endtask

  // tck parked in capture-dr stops the drain, so the buffer fills
  task automatic fifo_stall();
    logic o;
    int   k;
    u_sbst_jtag_ctl.step(1'b1, 1'b1, o);
    u_sbst_jtag_ctl.step(1'b0, 1'b1, o);
    repeat (20) @(posedge core_clk);
    #1;
    chk_bit(snap_ready, 1'b0);
    u_sbst_jtag_ctl.step(1'b1, 1'b1, o);
    u_sbst_jtag_ctl.step(1'b1, 1'b1, o);
    u_sbst_jtag_ctl.step(1'b0, 1'b1, o);
    for (k = 0; k < 50 && snap_ready !== 1'b1; k++)
    begin
      @(posedge core_clk);
      #1;
    end
    chk_bit(snap_ready, 1'b1);
  endtask

  initial
  begin
    repeat (10) @(posedge core_clk);
    #1 rst = 1'b0;
    @(posedge core_clk);
    #1 check_reset();
    snap_valid = 1'b1;
    u_sbst_jtag_ctl.reset5();
    foreach (codes[i])
      run_code(codes[i]);
    drive_cell();
    fifo_stall();
    final_report();
  end
endmodule
